// [rtl/cal_alu_top.sv]
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - File add: file, W0 and carry summed
// - Decode file add from fixed opcode byte
// - Destination bit: 0 to W0, 1 to file
// - Width bit: 0 word, 1 byte
// - File address is low thirteen bits
// - Default working register is W0 itself
// - Add with carry only clears zero
// - Literal add: literal, register, carry into it
// - Decode literal add: byte, width, literal, register
// - Literal from k bits, register from n
// - Three-register add with indirect modes
`include "cal_regs.svh"
module cal_alu_top
   import cal_pkg::*;
#(
   parameter int MEM_WORDS = 4096
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   localparam int IDX_W = $clog2(MEM_WORDS);
   localparam logic [16:0] MEM_END = `CAL_MEM_BASE + 17'(4 * MEM_WORDS);

   if (MEM_WORDS < 2 || MEM_WORDS > 4096 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad_depth
      $error("MEM_WORDS must be a power of two from 2 to 4096");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   cal_state_type   st_reg;
   cal_state_type   st_next;
   logic [15:0]     mem_array [MEM_WORDS];
   logic            mem_we;
   logic [IDX_W-1:0] mem_wi;
   logic [15:0]     mem_wd;

   function automatic logic [IDX_W-1:0] widx(input logic [15:0] byte_addr);
      return byte_addr[IDX_W:1];
   endfunction : widx

   function automatic logic [31:0] sr_pack(input cal_flags_type f);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[`CAL_SR_C]  = f.c;
      v[`CAL_SR_Z]  = f.z;
      v[`CAL_SR_OVF] = f.ovf;
      v[`CAL_SR_N]   = f.n;
      v[`CAL_SR_DCY] = f.dcy;
      return v;
   endfunction : sr_pack

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic        hit_instr, hit_status, hit_error, hit_wwin, hit_mwin, mapped;
   logic        apb_wr, exec_go;
   logic [31:0] rd_val;

   assign hit_instr  = paddr == `CAL_INSTR_OFS;
   assign hit_status = paddr == `CAL_STATUS_OFS;
   assign hit_error  = paddr == `CAL_ERROR_OFS;
   assign hit_wwin   = paddr[15:6] == `CAL_WORK_PAGE;
   assign hit_mwin   = ({1'b0, paddr} >= `CAL_MEM_BASE) && ({1'b0, paddr} < MEM_END);
   assign mapped     = (paddr[1:0] == 2'b00) && (hit_instr || hit_status || hit_error || hit_wwin || hit_mwin);
   assign apb_wr     = psel && penable && pwrite && mapped;
   assign exec_go    = apb_wr && hit_instr;
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && !mapped;
   assign prdata     = st_reg.rdata;

   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_instr) begin
         rd_val = {8'h00, st_reg.instr};
      end else if (hit_status) begin
         rd_val = sr_pack(st_reg.flags);
      end else if (hit_error) begin
         rd_val = {31'h0000_0000, st_reg.fault};
      end else if (hit_wwin) begin
         rd_val = {16'h0000, st_reg.w[paddr[5:2]]};
      end else if (hit_mwin) begin
         rd_val = {16'h0000, mem_array[paddr[IDX_W+1:2]]};
      end
   end

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   logic [23:0] op;
   cal_op_type  kind;
   logic        bm, dfile, slit, is_add, is_and;
   logic [12:0] faddr;
   logic [9:0]  lit;
   logic [3:0]  bsel, ssel, dsel, nsel;
   logic [2:0]  smode, dmode;

   assign op    = pwdata[23:0];
   assign bm    = op[14];
   assign dfile = op[13];
   assign faddr = op[12:0];
   assign lit   = op[13:4];
   assign nsel  = op[3:0];
   assign bsel  = op[18:15];
   assign dmode = op[13:11];
   assign dsel  = op[10:7];
   assign smode = op[6:4];
   assign ssel  = op[3:0];
   assign slit  = smode[2:1] == 2'b11;

   always_comb begin
      kind = CAL_OP_NONE;
      if (op[23:16] == `CAL_OPC_CADD_F && op[15]) begin
         kind = CAL_OP_CADD_F;
      end else if (op[23:16] == `CAL_OPC_CADD_L && op[15]) begin
         kind = CAL_OP_CADD_L;
      end else if (op[23:16] == `CAL_OPC_AND_F && !op[15]) begin
         kind = CAL_OP_AND_F;
      end else if (op[23:16] == `CAL_OPC_AND_L && !op[15]) begin
         kind = CAL_OP_AND_L;
      end else if (op[23:16] == `CAL_OPC_ASHR_F && op[15]) begin
         kind = CAL_OP_ASHR_F;
      end else if (op[23:19] == `CAL_OPC_CADD_W) begin
         kind = CAL_OP_CADD_W;
      end else if (op[23:19] == `CAL_OPC_AND_W) begin
         kind = CAL_OP_AND_W;
      end
   end

   assign is_add = kind == CAL_OP_CADD_F || kind == CAL_OP_CADD_L || kind == CAL_OP_CADD_W;
   assign is_and = kind == CAL_OP_AND_F || kind == CAL_OP_AND_L || kind == CAL_OP_AND_W;

   // ----------------------------------------
   // Operand fetch
   // ----------------------------------------
   logic [15:0]     fword, ea_s, ea_d, src_word, dst_word, opa, opb;
   cal_alu_out_type add_out, log_out, alu_out;

   assign ea_s     = cal_ea(smode, st_reg.w[ssel], bm);
   assign ea_d     = cal_ea(dmode, st_reg.w[dsel], bm);
   assign fword    = mem_array[widx({3'b000, faddr})];
   assign src_word = mem_array[widx(ea_s)];
   assign dst_word = mem_array[widx(ea_d)];

   always_comb begin
      opa = 16'h0000;
      opb = 16'h0000;
      case (kind)
         CAL_OP_CADD_F, CAL_OP_AND_F, CAL_OP_ASHR_F: begin
            opa = cal_pick(fword, bm, faddr[0]);
            opb = cal_pick(st_reg.w[`CAL_DEFAULT_WORK], bm, 1'b0);
         end
         CAL_OP_CADD_L, CAL_OP_AND_L: begin
            opa = cal_pick(st_reg.w[nsel], bm, 1'b0);
            // Only the low literal byte takes part in byte mode
            opb = cal_pick({6'h00, lit}, bm, 1'b0);
         end
         CAL_OP_CADD_W, CAL_OP_AND_W: begin
            opa = cal_pick(st_reg.w[bsel], bm, 1'b0);
            if (slit) begin
               opb = {11'h000, op[4:0]};
            end else if (smode == `CAL_AM_DIRECT) begin
               opb = cal_pick(st_reg.w[ssel], bm, 1'b0);
            end else begin
               opb = cal_pick(src_word, bm, ea_s[0]);
            end
         end
         default: begin
            opa = 16'h0000;
         end
      endcase
   end

   cal_adder u_adder (
      .opa  (opa),
      .opb  (opb),
      .bm   (bm),
      .fin  (st_reg.flags),
      .aout (add_out)
   );

   cal_logic u_logic (
      .opa   (opa),
      .opb   (opb),
      .shift (kind == CAL_OP_ASHR_F),
      .bm    (bm),
      .fin   (st_reg.flags),
      .aout  (log_out)
   );

   assign alu_out = is_add ? add_out : log_out;

   // ----------------------------------------
   // Next state and writeback
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      mem_we  = 1'b0;
      mem_wi  = '0;
      mem_wd  = 16'h0000;
      if (psel && !penable && !pwrite) begin
         st_next.rdata = rd_val;
      end
      if (exec_go) begin
         st_next.instr = op;
         if (kind == CAL_OP_NONE) begin
            st_next.fault = 1'b1;
         end else begin
            st_next.flags = alu_out.flags;
         end
         case (kind)
            CAL_OP_CADD_F, CAL_OP_AND_F, CAL_OP_ASHR_F: begin
               if (dfile) begin
                  mem_we = 1'b1;
                  mem_wi = widx({3'b000, faddr});
                  mem_wd = cal_merge(fword, alu_out.res, bm, faddr[0]);
               end else begin
                  st_next.w[`CAL_DEFAULT_WORK] = cal_merge(st_reg.w[`CAL_DEFAULT_WORK], alu_out.res, bm, 1'b0);
               end
            end
            CAL_OP_CADD_L, CAL_OP_AND_L: begin
               st_next.w[nsel] = cal_merge(st_reg.w[nsel], alu_out.res, bm, 1'b0);
            end
            CAL_OP_CADD_W, CAL_OP_AND_W: begin
               // Pointer updates first, so a direct result write to the same register wins
               if (!slit) begin
                  st_next.w[ssel] = cal_ptr_upd(smode, st_reg.w[ssel], bm);
               end
               if (dmode == `CAL_AM_DIRECT) begin
                  st_next.w[dsel] = cal_merge(st_reg.w[dsel], alu_out.res, bm, 1'b0);
               end else begin
                  st_next.w[dsel] = cal_ptr_upd(dmode, st_reg.w[dsel], bm);
                  mem_we = 1'b1;
                  mem_wi = widx(ea_d);
                  mem_wd = cal_merge(dst_word, alu_out.res, bm, ea_d[0]);
               end
            end
            default: begin
               st_next.instr = op;
            end
         endcase
      end else if (apb_wr) begin
         if (hit_status) begin
            st_next.flags.c  = pwdata[`CAL_SR_C];
            st_next.flags.z  = pwdata[`CAL_SR_Z];
            st_next.flags.ovf = pwdata[`CAL_SR_OVF];
            st_next.flags.n   = pwdata[`CAL_SR_N];
            st_next.flags.dcy = pwdata[`CAL_SR_DCY];
         end else if (hit_error) begin
            if (pwdata[0]) begin
               st_next.fault = 1'b0;
            end
         end else if (hit_wwin) begin
            st_next.w[paddr[5:2]] = pwdata[15:0];
         end else if (hit_mwin) begin
            mem_we = 1'b1;
            mem_wi = paddr[IDX_W+1:2];
            mem_wd = pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Data memory has no reset; software loads it before use
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem_array[mem_wi] <= mem_wd;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [15:0] chk_lit_sum, chk_file_sum;

   assign chk_lit_sum  = st_reg.w[nsel] + {6'h00, lit} + {15'h0000, st_reg.flags.c};
   assign chk_file_sum = fword + st_reg.w[0] + {15'h0000, st_reg.flags.c};

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_zero_sticky: assert property (
      exec_go && is_add && !st_reg.flags.z |=> !st_reg.flags.z
   ) else $error("zero flag set by add with carry");

   chk_lit_sum_word: assert property (
      exec_go && kind == CAL_OP_CADD_L && !bm |=> st_reg.w[$past(nsel)] == $past(chk_lit_sum)
   ) else $error("literal add result wrong");

   chk_w0_dest: assert property (
      exec_go && kind == CAL_OP_CADD_F && !dfile && !bm |=> st_reg.w[0] == $past(chk_file_sum)
   ) else $error("file add to W0 wrong");

   chk_file_dest: assert property (
      exec_go && kind == CAL_OP_CADD_F && dfile |=> st_reg.w[0] == $past(st_reg.w[0])
   ) else $error("W0 changed on file destination");

   chk_byte_keep: assert property (
      exec_go && kind == CAL_OP_CADD_L && bm |=> st_reg.w[$past(nsel)][15:8] == $past(st_reg.w[nsel][15:8])
   ) else $error("byte add touched upper byte");

   chk_and_flags: assert property (
      exec_go && is_and |=> st_reg.flags.c == $past(st_reg.flags.c) && st_reg.flags.ovf == $past(st_reg.flags.ovf)
                            && st_reg.flags.dcy == $past(st_reg.flags.dcy)
   ) else $error("AND changed arithmetic flags");

   chk_shift_carry: assert property (
      exec_go && kind == CAL_OP_ASHR_F |=> st_reg.flags.c == $past(opa[0])
   ) else $error("shift carry wrong");

   chk_post_inc: assert property (
      exec_go && kind == CAL_OP_CADD_W && smode == `CAL_AM_POSTINC && !bm && ssel != dsel
      |=> st_reg.w[$past(ssel)] == $past(st_reg.w[ssel]) + 16'h0002
   ) else $error("source post-increment wrong");

   chk_file_decode: assert property (
      exec_go && op[23:15] == {`CAL_OPC_CADD_F, 1'b1} |-> kind == CAL_OP_CADD_F
   ) else $error("file add not decoded");

   chk_unmapped_err: assert property (
      psel && penable && paddr[1:0] != 2'b00 |-> pslverr ##1 st_reg.instr == $past(st_reg.instr)
   ) else $error("unaligned access not refused");

   cov_indirect_add: cover property (exec_go && kind == CAL_OP_CADD_W && dmode != `CAL_AM_DIRECT);
   cov_byte_shift: cover property (exec_go && kind == CAL_OP_ASHR_F && bm ##1 st_reg.flags.c);
   cov_zero_clear: cover property (st_reg.flags.z && exec_go && is_add ##1 !st_reg.flags.z);
   cov_bad_opcode: cover property (exec_go && kind == CAL_OP_NONE);
endmodule : cal_alu_top

// [rtl/cal_regs.svh]
`ifndef CAL_REGS_SVH
`define CAL_REGS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CAL_INSTR_OFS    16'h0000
`define CAL_STATUS_OFS   16'h0004
`define CAL_ERROR_OFS    16'h0008
`define CAL_WORK_BASE    16'h0040
`define CAL_WORK_PAGE    10'h001
`define CAL_MEM_BASE     17'h08000
// ----------------------------------------
// Status bit positions and reset
// ----------------------------------------
`define CAL_SR_C         0
`define CAL_SR_Z         1
`define CAL_SR_OVF       2
`define CAL_SR_N         3
`define CAL_SR_DCY       8
`define CAL_FLAGS_RESET  5'h00
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define CAL_OPC_CADD_F   8'hB4
`define CAL_OPC_CADD_L   8'hB0
`define CAL_OPC_AND_F    8'hB6
`define CAL_OPC_AND_L    8'hB2
`define CAL_OPC_ASHR_F   8'hD5
`define CAL_OPC_CADD_W   5'h09
`define CAL_OPC_AND_W    5'h0C
// ----------------------------------------
// Addressing modes
// ----------------------------------------
`define CAL_AM_DIRECT    3'h0
`define CAL_AM_POSTINC   3'h2
`define CAL_AM_POSTDEC   3'h3
`define CAL_AM_PREINC    3'h4
`define CAL_AM_PREDEC    3'h5
`define CAL_DEFAULT_WORK 4'h0
`endif

// [rtl/cal_pkg.sv]
`include "cal_regs.svh"
package cal_pkg;
   typedef struct packed {
      logic dcy;
      logic n;
      logic ovf;
      logic z;
      logic c;
   } cal_flags_type;

   typedef struct packed {
      logic [15:0]   res;
      cal_flags_type flags;
   } cal_alu_out_type;

   typedef enum logic [2:0] {
      CAL_OP_NONE, CAL_OP_CADD_F, CAL_OP_CADD_L, CAL_OP_CADD_W,
      CAL_OP_AND_F, CAL_OP_AND_L, CAL_OP_AND_W, CAL_OP_ASHR_F
   } cal_op_type;

   typedef struct packed {
      logic [23:0]       instr;
      cal_flags_type     flags;
      logic              fault;
      logic [15:0][15:0] w;
      logic [31:0]       rdata;
   } cal_state_type;

   function automatic logic [15:0] cal_pick(input logic [15:0] word, input logic bm, input logic hi);
      return bm ? {8'h00, (hi ? word[15:8] : word[7:0])} : word;
   endfunction : cal_pick

   function automatic logic [15:0] cal_merge(input logic [15:0] old, input logic [15:0] val,
                                             input logic bm, input logic hi);
      if (!bm) return val;
      return hi ? {val[7:0], old[7:0]} : {old[15:8], val[7:0]};
   endfunction : cal_merge

   function automatic logic [15:0] cal_step(input logic bm);
      return bm ? 16'h0001 : 16'h0002;
   endfunction : cal_step

   // Pre-modify modes address through the adjusted pointer
   function automatic logic [15:0] cal_ea(input logic [2:0] mode, input logic [15:0] ptr, input logic bm);
      if (mode == `CAL_AM_PREINC) return ptr + cal_step(bm);
      if (mode == `CAL_AM_PREDEC) return ptr - cal_step(bm);
      return ptr;
   endfunction : cal_ea

   function automatic logic [15:0] cal_ptr_upd(input logic [2:0] mode, input logic [15:0] ptr, input logic bm);
      if (mode == `CAL_AM_POSTINC || mode == `CAL_AM_PREINC) return ptr + cal_step(bm);
      if (mode == `CAL_AM_POSTDEC || mode == `CAL_AM_PREDEC) return ptr - cal_step(bm);
      return ptr;
   endfunction : cal_ptr_upd
endpackage : cal_pkg

// [rtl/cal_adder.sv]
`timescale 1ns/100ps
module cal_adder
   import cal_pkg::*;
(
   input  wire logic [15:0]     opa,
   input  wire logic [15:0]     opb,
   input  wire logic            bm,
   input  wire cal_flags_type   fin,
   output cal_alu_out_type      aout
);
   logic [16:0] sum_w;
   logic [8:0]  sum_b;
   logic [4:0]  sum_n;
   logic [15:0] res;
   logic        sa, sb, sr;

   assign sum_w = {1'b0, opa} + {1'b0, opb} + {16'h0000, fin.c};
   assign sum_b = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, fin.c};
   assign sum_n = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, fin.c};
   assign res   = bm ? {8'h00, sum_b[7:0]} : sum_w[15:0];
   assign sa    = bm ? opa[7] : opa[15];
   assign sb    = bm ? opb[7] : opb[15];
   assign sr    = bm ? res[7] : res[15];

   always_comb begin
      aout.res      = res;
      aout.flags.c  = bm ? sum_b[8] : sum_w[16];
      aout.flags.dcy = bm ? sum_n[4] : sum_b[8];
      aout.flags.ovf = (sa == sb) && (sr != sa);
      aout.flags.n  = sr;
      // Zero may only be cleared here, never set
      aout.flags.z  = fin.z && (bm ? (res[7:0] == 8'h00) : (res == 16'h0000));
   end
endmodule : cal_adder

// [rtl/cal_logic.sv]
`timescale 1ns/100ps
module cal_logic
   import cal_pkg::*;
(
   input  wire logic [15:0]     opa,
   input  wire logic [15:0]     opb,
   input  wire logic            shift,
   input  wire logic            bm,
   input  wire cal_flags_type   fin,
   output cal_alu_out_type      aout
);
   logic [15:0] res;

   always_comb begin
      if (shift) begin
         res = bm ? {8'h00, opa[7], opa[7:1]} : {opa[15], opa[15:1]};
      end else begin
         res = opa & opb;
      end
      aout.res      = res;
      aout.flags    = fin;
      aout.flags.c  = shift ? opa[0] : fin.c;
      aout.flags.n  = bm ? res[7] : res[15];
      aout.flags.z  = bm ? (res[7:0] == 8'h00) : (res == 16'h0000);
   end
endmodule : cal_logic

// [testbench/cal_apb_master.sv]
`timescale 1ns/100ps
module cal_apb_master (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [15:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 16'h0000;
      pwdata  = 32'h0000_0000;
   end

   // ----
   // One transfer: setup, then access held until pready is sampled
   // ----
   task automatic xfer(input logic wr, input logic [15:0] ad, input logic [31:0] dt,
                       output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines toggle so stale values are never mistaken for live ones
      paddr   <= ~ad;
      pwdata  <= ~dt;
   endtask : xfer
endmodule : cal_apb_master

// [testbench/cal_alu_top_tb.sv]
`timescale 1ns/100ps
`include "cal_regs.svh"
module cal_alu_top_tb;
   import cal_pkg::*;
   logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr, bm, dst;
   logic [15:0]     paddr, mw, wv, a, ew, em;
   logic [31:0]     pwdata, prdata, r, q;
   logic [12:0]     f;
   logic [9:0]      k;
   logic [3:0]      n;
   logic [7:0]      ob;
   int              fails, compares, cycles, op;
   cal_flags_type   fl;
   cal_alu_out_type e;

   cal_alu_top #(.MEM_WORDS(4096)) u_cal_alu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
                                                   .pwdata, .prdata, .pready, .pslverr);
   cal_apb_master u_cal_apb_master (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                                    .pready, .pslverr);

   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   // ----
   // Reference arithmetic; op 0 add with carry, 1 and, 2 shift right
   // ----
   function automatic cal_alu_out_type model(input int op, input logic [15:0] a, input logic [15:0] b,
                                             input logic bm, input cal_flags_type fi);
      cal_alu_out_type o;
      logic [16:0]     s;
      logic [15:0]     m;
      int              hb;
      o.flags = fi;
      hb = bm ? 7 : 15;
      m = bm ? 16'h00FF : 16'hFFFF;
      a = a & m;
      b = b & m;
      if (op == 0) begin
         s = a + b + fi.c;
         o.res = s[15:0] & m;
         o.flags.c = s[hb+1];
         o.flags.dcy = bm ? ((a[3:0] + b[3:0] + fi.c) > 5'h0F) : ((a[7:0] + b[7:0] + fi.c) > 9'h0FF);
         o.flags.ovf = (a[hb] == b[hb]) && (o.res[hb] != a[hb]);
         o.flags.z = fi.z && (o.res == 16'h0000);
      end else begin
         o.res = (op == 1) ? (a & b) : ((a >> 1) | (a & (16'h0001 << hb)));
         if (op == 2) o.flags.c = a[0];
         o.flags.z = (o.res == 16'h0000);
      end
      o.flags.n = o.res[hb];
      return o;
   endfunction : model

   function automatic logic [31:0] st(input cal_flags_type x);
      return {23'h0, x.dcy, 4'h0, x.n, x.ovf, x.z, x.c};
   endfunction : st

   function automatic logic [15:0] wa(input logic [3:0] i);
      return `CAL_WORK_BASE + {10'h000, i, 2'b00};
   endfunction : wa

   // ----
   // Bus helpers and reporting
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] ex, input string what);
      compares++;
      if (seen !== ex) begin
         fails++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, ex);
      end
   endtask : check

   task automatic wr(input logic [15:0] ad, input logic [31:0] dt);
      u_cal_apb_master.xfer(1'b1, ad, dt, q, lerr);
   endtask : wr

   task automatic rd(input logic [15:0] ad, input logic [31:0] ex, input string what);
      u_cal_apb_master.xfer(1'b0, ad, 32'h0000_0000, q, lerr);
      check(q, ex, what);
   endtask : rd

   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // ----
   // Main sequence
   // ----
   initial begin
      fails = 0;
      compares = 0;
      cycles = 0;
      presetn = 1'b0;
      void'($urandom(32'h9B25));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`CAL_STATUS_OFS, 32'h0, "status reset");
      rd(`CAL_INSTR_OFS, 32'h0, "instr reset");
      rd(wa(4'h5), 32'h0, "w5 reset");
      $display("test reset done");

      for (int i = 0; i < 80; i++) begin
         op = $urandom_range(3, 0);
         r = $urandom;
         bm = r[30];
         dst = r[31];
         f = r[28:16];
         fl = r[4:0];
         mw = 16'($urandom);
         wv = 16'($urandom);
         if (i == 0) begin
            op = 3;
            bm = 1'b0;
            wv = 16'hFC00;
            r[13:4] = 10'h3FF;
            fl = 5'b00011;
         end
         if (i == 1) begin
            {op, bm, dst, mw, wv, fl} = {32'd0, 2'b10, 16'h7F7F, 16'h0001, 5'b00000};
         end
         if (i == 2) begin
            {op, bm, mw} = {32'd2, 1'b0, 16'h8001};
         end
         wr(`CAL_STATUS_OFS, st(fl));
         if (op == 3) begin
            n = r[3:0];
            k = r[13:4];
            if (bm) k[9:8] = 2'b00;
            wr(wa(n), {16'h0, wv});
            wr(`CAL_INSTR_OFS, {`CAL_OPC_CADD_L, 1'b1, bm, k, n});
            e = model(0, {6'h00, k}, wv, bm, fl);
            rd(wa(n), {16'h0, bm ? {wv[15:8], e.res[7:0]} : e.res}, "lit add");
         end else begin
            ob = (op == 0) ? `CAL_OPC_CADD_F : (op == 1) ? `CAL_OPC_AND_F : `CAL_OPC_ASHR_F;
            wr(16'(`CAL_MEM_BASE + 4 * f[12:1]), {16'h0, mw});
            wr(wa(`CAL_DEFAULT_WORK), {16'h0, wv});
            wr(`CAL_INSTR_OFS, {ob, op != 1, bm, dst, f});
            a = (bm && f[0]) ? {8'h00, mw[15:8]} : mw;
            e = model(op, a, wv, bm, fl);
            ew = dst ? wv : bm ? {wv[15:8], e.res[7:0]} : e.res;
            em = !dst ? mw : !bm ? e.res : f[0] ? {e.res[7:0], mw[7:0]} : {mw[15:8], e.res[7:0]};
            rd(wa(4'h0), {16'h0, ew}, "file dest w0");
            rd(16'(`CAL_MEM_BASE + 4 * f[12:1]), {16'h0, em}, "file dest mem");
         end
         rd(`CAL_STATUS_OFS, st(e.flags), "flags");
      end
      $display("test random ops done");

      wr(wa(4'h1), 32'h0000_0100);
      wr(wa(4'h2), 32'h0000_1234);
      wr(16'(`CAL_MEM_BASE + 4 * 16'h0080), 32'h0000_F00D);
      fl = 5'b00011;
      wr(`CAL_STATUS_OFS, st(fl));
      wr(`CAL_INSTR_OFS, {`CAL_OPC_CADD_W, 4'h2, 1'b0, 3'h0, 4'h3, 3'h2, 4'h1});
      e = model(0, 16'h1234, 16'hF00D, 1'b0, fl);
      rd(wa(4'h3), {16'h0, e.res}, "three reg sum");
      rd(wa(4'h1), 32'h0000_0102, "post increment");
      rd(`CAL_STATUS_OFS, st(e.flags), "three reg flags");
      $display("test three register done");

      fl = 5'b11111;
      wr(`CAL_STATUS_OFS, st(fl));
      wr(wa(4'h4), 32'h0000_12D0);
      wr(`CAL_INSTR_OFS, {`CAL_OPC_AND_L, 1'b0, 1'b0, 10'h333, 4'h4});
      e = model(1, 16'h0333, 16'h12D0, 1'b0, fl);
      rd(wa(4'h4), {16'h0, e.res}, "and literal");
      rd(`CAL_STATUS_OFS, st(e.flags), "and literal flags");
      fl = e.flags;
      // Short literal source, pre-decremented indirect destination
      wr(`CAL_INSTR_OFS, {`CAL_OPC_AND_W, 4'h2, 1'b0, 3'h5, 4'h1, 2'b11, 5'h1F});
      e = model(1, 16'h1234, 16'h001F, 1'b0, fl);
      rd(16'(`CAL_MEM_BASE + 4 * 16'h0080), {16'h0, e.res}, "and short literal to memory");
      rd(wa(4'h1), 32'h0000_0100, "pre decrement dest");
      rd(`CAL_STATUS_OFS, st(e.flags), "and short literal flags");
      $display("test logic forms done");

      rd(16'h0020, 32'h0, "unmapped read");
      check({31'h0, lerr}, 32'h1, "unmapped error");
      rd(16'h0002, 32'h0, "unaligned read");
      check({31'h0, lerr}, 32'h1, "unaligned error");
      wr(`CAL_INSTR_OFS, 32'h00FF_FFFF);
      rd(`CAL_ERROR_OFS, 32'h1, "fault set");
      rd(`CAL_STATUS_OFS, st(e.flags), "fault keeps flags");
      wr(`CAL_ERROR_OFS, 32'h1);
      rd(`CAL_ERROR_OFS, 32'h0, "fault clear");
      $display("test errors done");
      conclude();
   end
endmodule : cal_alu_top_tb
